// ===== pkg/tfrc_regs.vh
// Register offsets, field positions, reset values and timing counts of the framer control block.
`ifndef TFRC_REGS_VH
`define TFRC_REGS_VH
`define TFRC_ADDR_TCR     8'h35
`define TFRC_ADDR_RCR     8'h2C
`define TFRC_ADDR_TTR0    8'h39
`define TFRC_ADDR_TTR1    8'h3A
`define TFRC_ADDR_TTR2    8'h3B
`define TFRC_ADDR_TRANSMIT_DATA_LINK_REGISTER    8'h3C
`define TFRC_ADDR_STAT    8'h3D
`define TFRC_ADDR_CCR     8'h37
`define TFRC_RST_CTRL     8'h00
`define TFRC_RST_TTR      24'h000000
`define TFRC_B_FALLBACK   7
`define TFRC_B_FPT        6
`define TFRC_B_CPT        5
`define TFRC_B_ROBBED_BIT_SIGNALING_ENABLE       4
`define TFRC_B_GB7        3
`define TFRC_B_LINK       2
`define TFRC_B_BLUE       1
`define TFRC_B_YEL        0
`define TFRC_B_RCS        7
`define TFRC_B_RZB        6
`define TFRC_B_RECEIVE_SYNC_DOUBLE_WIDE       5
`define TFRC_B_RSM        4
`define TFRC_B_RECEIVE_SYNC_DIRECTION       3
`define TFRC_B_RD4Y       2
`define TFRC_B_FS_ERROR_REPORT_ENABLE       1
`define TFRC_B_MOS        0
`define TFRC_B_TD4Y       1
`define TFRC_B_RESE       2
`define TFRC_IDLE_CODE    8'h7F
`define TFRC_CLK_LOSS_CYC 8'h10
`define TFRC_BITS_FRAME   8'hC1
`endif

// ===== rtl/tfrc_framer_ctrl.v
// Control-bit datapath of a T1 framer: register port, transmit formatter, receive options.
//
// Contract
// - Receive code: 7F idle or milliwatt.
// - Receive zero byte interchange decode enable.
// - Double-wide receive sync in signaling frames.
// - Receive sync marks frame or multiframe.
// - Receive sync pin output or input.
// - Receive yellow form: bit2 zeros or S12.
// - Path counter includes Fs errors when set.
// - Counter counts F errors or OOS multiframes.
// - Fall back to receive clock on loss.
// - Framing bits internal or from serial input.
// - CRC6 bits internal or from serial input.
// - Robbed-bit signaling insertion, per-channel block.
// - Bit 7 stuffing global or per channel.
// - Link bits from register or pin.
// - Blue alarm sends unframed all ones.
// - Yellow alarm transmit enable.
// - D4 yellow form per transmit select bit.
`timescale 1ns/10ps
`include "tfrc_regs.vh"

module tfrc_framer_ctrl (
  input  wire        clock,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata_ff,
  input  wire        transmit_clock_input,
  input  wire        recv_clock_input,
  input  wire        transmit_serial_input,
  input  wire        transmit_link_pin,
  input  wire        tx_sig_bit,
  input  wire        tx_esf_mode,
  input  wire        rx_valid,
  output reg         rx_ready_ff,
  input  wire [7:0]  rx_byte,
  input  wire        rx_code_sub,
  input  wire        rx_frame_start,
  input  wire        rx_mf_start,
  input  wire        rx_sig_frame,
  input  wire        rx_fbit_err,
  input  wire        rx_fs_err,
  input  wire        rx_oos_mf,
  input  wire        receive_sync_pin_in,
  output reg         receive_sync_pin_out_ff,
  output reg         receive_sync_pin_oe_ff,
  output reg         out_valid_ff,
  input  wire        out_ready,
  output reg  [7:0]  out_byte_ff,
  output reg         line_out_positive_ff,
  output reg         line_out_negative_ff,
  output reg         tx_clock_sel_ff,
  output reg         zbtsi_decode_en_ff,
  output reg         rx_yellow_form_ff,
  output reg  [15:0] pcv_count_ff,
  output reg  [15:0] mos_count_ff
);

  // ******************************************************************
  // Registers
  // ******************************************************************
  reg [7:0]  tcr_ff;
  reg [7:0]  rcr_ff;
  reg [7:0]  ccr_ff;
  reg [23:0] ttr_ff;
  reg [7:0]  transmit_data_link_register_ff;
  reg [2:0]  tsync_ff;
  reg [2:0]  receive_sync_pin_ff;
  reg [2:0]  transmit_clock_input_ff;
  reg [7:0]  loss_cnt_ff;
  reg [7:0]  bit_cnt_ff;
  reg [4:0]  chan_ff;
  reg [2:0]  mw_idx_ff;
  reg        sync_ext_ff;
  reg        tx_bit_ff;
  reg        fbit_ff;
  reg        receive_sync_pin_in_ff;

  reg  [7:0] nxt_rdata;
  reg        nxt_fbit;
  reg        nxt_tx_bit;
  wire       transmit_clock_input_edge;
  wire       line_edge;
  wire       in_fbit;
  wire [7:0] slot_index;

  // One byte of the eight-byte milliwatt sequence, chosen by its position.
  function [7:0] milliwatt;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: milliwatt = 8'h1E;
        3'h1: milliwatt = 8'h0B;
        3'h2: milliwatt = 8'h0B;
        3'h3: milliwatt = 8'h1E;
        3'h4: milliwatt = 8'h9E;
        3'h5: milliwatt = 8'h8B;
        3'h6: milliwatt = 8'h8B;
        default: milliwatt = 8'h9E;
      endcase
    end
  endfunction

  // Address match, shared by the write decode.
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Event counter step; both error counters share it.
  function [15:0] count_up;
    input [15:0] value;
    input        event_seen;
    begin
      count_up = event_seen ? value + 16'h0001 : value;
    end
  endfunction

  // Read mux; unmapped offsets read as zero.
  always @* begin
    case (reg_addr)
      `TFRC_ADDR_TCR:  nxt_rdata = tcr_ff;
      `TFRC_ADDR_RCR:  nxt_rdata = rcr_ff;
      `TFRC_ADDR_CCR:  nxt_rdata = ccr_ff;
      `TFRC_ADDR_TTR0: nxt_rdata = ttr_ff[7:0];
      `TFRC_ADDR_TTR1: nxt_rdata = ttr_ff[15:8];
      `TFRC_ADDR_TTR2: nxt_rdata = ttr_ff[23:16];
      `TFRC_ADDR_TRANSMIT_DATA_LINK_REGISTER: nxt_rdata = transmit_data_link_register_ff;
      `TFRC_ADDR_STAT: nxt_rdata = {6'h00, tx_clock_sel_ff, receive_sync_pin_in_ff};
      default:         nxt_rdata = 8'h00;
    endcase
  end

  // Control registers reset to zero; the transparency bits are one per channel.
  always @(posedge clock) begin
    if (reset) begin
      tcr_ff       <= `TFRC_RST_CTRL;
      rcr_ff       <= `TFRC_RST_CTRL;
      ccr_ff       <= `TFRC_RST_CTRL;
      ttr_ff       <= `TFRC_RST_TTR;
      transmit_data_link_register_ff      <= `TFRC_RST_CTRL;
      reg_rdata_ff <= 8'h00;
    end else begin
      // Read data stand for the one cycle after the strobe and are zero otherwise.
      reg_rdata_ff <= reg_read ? nxt_rdata : 8'h00;
      if (reg_write) begin
        if (hit(reg_addr, `TFRC_ADDR_TCR))  tcr_ff  <= reg_wdata;
        if (hit(reg_addr, `TFRC_ADDR_RCR))  rcr_ff  <= reg_wdata;
        if (hit(reg_addr, `TFRC_ADDR_CCR))  ccr_ff  <= reg_wdata;
        if (hit(reg_addr, `TFRC_ADDR_TTR0)) ttr_ff[7:0]   <= reg_wdata;
        if (hit(reg_addr, `TFRC_ADDR_TTR1)) ttr_ff[15:8]  <= reg_wdata;
        if (hit(reg_addr, `TFRC_ADDR_TTR2)) ttr_ff[23:16] <= reg_wdata;
        if (hit(reg_addr, `TFRC_ADDR_TRANSMIT_DATA_LINK_REGISTER)) transmit_data_link_register_ff <= reg_wdata;
      end
    end
  end

  // ******************************************************************
  // Pin synchronisers and clock loss detection
  // ******************************************************************
  // Pins pass three flip-flops; a level counts once the last two agree.
  assign transmit_clock_input_edge = transmit_clock_input_ff[2] != transmit_clock_input_ff[1];

  always @(posedge clock) begin
    if (reset) begin
      transmit_clock_input_ff         <= 3'h0;
      tsync_ff        <= 3'h0;
      receive_sync_pin_ff        <= 3'h0;
      loss_cnt_ff     <= 8'h00;
      tx_clock_sel_ff <= 1'b0;
      receive_sync_pin_in_ff     <= 1'b0;
    end else begin
      transmit_clock_input_ff  <= {transmit_clock_input_ff[1:0], transmit_clock_input};
      tsync_ff <= {tsync_ff[1:0], recv_clock_input};
      receive_sync_pin_ff <= {receive_sync_pin_ff[1:0], receive_sync_pin_in};
      if (receive_sync_pin_ff[2] == receive_sync_pin_ff[1])
        receive_sync_pin_in_ff <= receive_sync_pin_ff[2];
      // A line clock that holds still for the loss count hands the formatter over.
      if (transmit_clock_input_edge)
        loss_cnt_ff <= 8'h00;
      else if (loss_cnt_ff != `TFRC_CLK_LOSS_CYC)
        loss_cnt_ff <= loss_cnt_ff + 8'h01;
      // The formatter returns to the transmit clock as soon as it toggles again.
      tx_clock_sel_ff <= tcr_ff[`TFRC_B_FALLBACK] &&
                         (loss_cnt_ff == `TFRC_CLK_LOSS_CYC) && !transmit_clock_input_edge;
    end
  end

  // ******************************************************************
  // Transmit formatter
  // ******************************************************************
  // The bit counter follows the transmit line clock, or the recovered receive
  // clock while the fallback has taken over; counting both at once would run
  // the frame too fast whenever the two clocks drift apart.
  assign line_edge  = tx_clock_sel_ff ? (tsync_ff[2] != tsync_ff[1]) : transmit_clock_input_edge;
  assign in_fbit    = (bit_cnt_ff == 8'h00);
  assign slot_index = bit_cnt_ff - 8'h01;

  // Bit source priority: F-bit slot, signaling, yellow, bit 7 stuffing, payload.
  always @* begin
    nxt_fbit   = fbit_ff;
    nxt_tx_bit = transmit_serial_input;
    if (in_fbit) begin
      if (tx_esf_mode)
        nxt_fbit = tcr_ff[`TFRC_B_LINK] ? transmit_link_pin : transmit_data_link_register_ff[0];
      else
        nxt_fbit = 1'b0;
      if (tcr_ff[`TFRC_B_FPT] || tcr_ff[`TFRC_B_CPT])
        nxt_tx_bit = transmit_serial_input;
      else
        nxt_tx_bit = fbit_ff;
    end else if (tcr_ff[`TFRC_B_ROBBED_BIT_SIGNALING_ENABLE] && !ttr_ff[chan_ff] && bit_cnt_ff[2:0] == 3'h0) begin
      nxt_tx_bit = tx_sig_bit;
    end else if (tcr_ff[`TFRC_B_YEL] && !tx_esf_mode &&
                 !ccr_ff[`TFRC_B_TD4Y] && bit_cnt_ff[2:0] == 3'h2) begin
      // The frame 12 S-bit form is set by the F-bit generator outside this block.
      nxt_tx_bit = 1'b0;
    end else if (bit_cnt_ff[2:0] == 3'h7 &&
                 (tcr_ff[`TFRC_B_GB7] || ttr_ff[chan_ff])) begin
      nxt_tx_bit = 1'b1;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      bit_cnt_ff           <= 8'h00;
      chan_ff              <= 5'h00;
      tx_bit_ff            <= 1'b0;
      fbit_ff              <= 1'b0;
      line_out_positive_ff <= 1'b0;
      line_out_negative_ff <= 1'b0;
    end else begin
      if (line_edge) begin
        if (bit_cnt_ff == `TFRC_BITS_FRAME - 8'h01)
          bit_cnt_ff <= 8'h00;
        else
          bit_cnt_ff <= bit_cnt_ff + 8'h01;
        chan_ff <= in_fbit ? 5'h00 : slot_index[7:3];
      end
      fbit_ff   <= nxt_fbit;
      tx_bit_ff <= nxt_tx_bit;
      // Blue alarm overrides framing and payload alike, so no F-bit survives.
      if (tcr_ff[`TFRC_B_BLUE]) begin
        line_out_positive_ff <= 1'b1;
        line_out_negative_ff <= 1'b1;
      end else begin
        line_out_positive_ff <= tx_bit_ff;
        line_out_negative_ff <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Receive side: two-entry buffer, code substitution, sync pin, counters
  // ******************************************************************
  // Two-entry buffer: buf0_ff holds the head word, buf1_ff the word behind it.
  reg [7:0] buf0_ff;
  reg [7:0] buf1_ff;
  reg [1:0] cnt_ff;
  reg        nxt_rx_ready;
  reg        nxt_out_valid;
  reg  [7:0] nxt_out_byte;
  wire      push;
  wire      pop;
  wire [7:0] sub_byte;

  assign sub_byte = !rx_code_sub ? rx_byte :
                    rcr_ff[`TFRC_B_RCS] ? milliwatt(mw_idx_ff) : `TFRC_IDLE_CODE;
  assign push = rx_valid && rx_ready_ff;
  assign pop  = out_valid_ff && out_ready;

  // Output stage by fill level: empty passes the new word straight through,
  // one word held refuses only a push without a pop, two held refuse until a pop.
  always @* begin
    nxt_rx_ready  = 1'b1;
    nxt_out_valid = 1'b0;
    nxt_out_byte  = buf0_ff;
    case (cnt_ff)
      2'h0: begin
        nxt_out_valid = push;
        nxt_out_byte  = push ? sub_byte : buf0_ff;
      end
      2'h1: begin
        nxt_rx_ready  = !(push && !pop);
        nxt_out_valid = !pop || push;
        nxt_out_byte  = (pop && push) ? sub_byte : buf0_ff;
      end
      default: begin
        nxt_rx_ready  = pop;
        nxt_out_valid = 1'b1;
        nxt_out_byte  = pop ? buf1_ff : buf0_ff;
      end
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      buf0_ff      <= 8'h00;
      buf1_ff      <= 8'h00;
      cnt_ff       <= 2'h0;
      out_valid_ff <= 1'b0;
      out_byte_ff  <= 8'h00;
      rx_ready_ff  <= 1'b0;
      mw_idx_ff    <= 3'h0;
    end else begin
      // The sequence index moves only while the sequence is sent, so it starts at byte one.
      if (push && rx_code_sub && rcr_ff[`TFRC_B_RCS])
        mw_idx_ff <= mw_idx_ff + 3'h1;
      case ({push, pop})
        2'b10: begin
          if (cnt_ff == 2'h0) buf0_ff <= sub_byte;
          else buf1_ff <= sub_byte;
          cnt_ff <= cnt_ff + 2'h1;
        end
        2'b01: begin
          buf0_ff <= buf1_ff;
          cnt_ff  <= cnt_ff - 2'h1;
        end
        2'b11: begin
          // One word held: the pushed word replaces the departing head.
          if (cnt_ff == 2'h1) buf0_ff <= sub_byte;
          else begin
            buf0_ff <= buf1_ff;
            buf1_ff <= sub_byte;
          end
        end
        default: cnt_ff <= cnt_ff;
      endcase
      rx_ready_ff  <= nxt_rx_ready;
      out_valid_ff <= nxt_out_valid;
      out_byte_ff  <= nxt_out_byte;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      sync_ext_ff             <= 1'b0;
      receive_sync_pin_out_ff <= 1'b0;
      receive_sync_pin_oe_ff  <= 1'b0;
      zbtsi_decode_en_ff      <= 1'b0;
      rx_yellow_form_ff       <= 1'b0;
      pcv_count_ff            <= 16'h0000;
      mos_count_ff            <= 16'h0000;
    end else begin
      // Option bits are registered so that every output comes from a flip-flop.
      zbtsi_decode_en_ff <= rcr_ff[`TFRC_B_RZB];
      rx_yellow_form_ff  <= rcr_ff[`TFRC_B_RD4Y];
      // Input mode needs the receive elastic store; otherwise the pin stays driven.
      receive_sync_pin_oe_ff <= !(rcr_ff[`TFRC_B_RECEIVE_SYNC_DIRECTION] && ccr_ff[`TFRC_B_RESE]);
      // The double-wide stretch adds one cycle after a signaling-frame mark.
      sync_ext_ff <= rcr_ff[`TFRC_B_RECEIVE_SYNC_DOUBLE_WIDE] && !rcr_ff[`TFRC_B_RSM] &&
                     rx_frame_start && rx_sig_frame;
      receive_sync_pin_out_ff <= (rcr_ff[`TFRC_B_RSM] ? rx_mf_start : rx_frame_start) ||
                                 sync_ext_ff;
      // Fs errors reach the path counter only while reporting them is enabled.
      pcv_count_ff <= count_up(pcv_count_ff,
                               rx_fbit_err || (rx_fs_err && rcr_ff[`TFRC_B_FS_ERROR_REPORT_ENABLE]));
      mos_count_ff <= count_up(mos_count_ff,
                               rcr_ff[`TFRC_B_MOS] ? rx_oos_mf : rx_fbit_err);
    end
  end

endmodule // tfrc_framer_ctrl

// ===== sim/tfrc_ctrl_sva.sv
// Port-level checker for the framer control block.
`timescale 1ns/10ps
`include "tfrc_regs.vh"
module tfrc_ctrl_sva (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic       transmit_clock_input,
  input wire logic       rx_valid,
  input wire logic       rx_ready_ff,
  input wire logic       out_valid_ff,
  input wire logic       out_ready,
  input wire logic [7:0] out_byte_ff,
  input wire logic       line_out_positive_ff,
  input wire logic       line_out_negative_ff,
  input wire logic       tx_clock_sel_ff,
  input wire logic       zbtsi_decode_en_ff,
  input wire logic       rx_yellow_form_ff,
  input wire logic       receive_sync_pin_oe_ff
);
  logic [7:0] tcr_ff;
  logic [7:0] rcr_ff;
  logic [5:0] idle_ff;
  logic       transmit_clock_input_ff;
  // Shadow copies of the transmit and receive control registers and a count of cycles without a line clock edge.
  always_ff @(posedge clock) begin
    transmit_clock_input_ff <= transmit_clock_input;
    if (reset) begin
      tcr_ff  <= 8'h00;
      rcr_ff  <= 8'h00;
      idle_ff <= 6'h00;
    end else begin
      if (reg_write && reg_addr == `TFRC_ADDR_TCR) tcr_ff <= reg_wdata;
      if (reg_write && reg_addr == `TFRC_ADDR_RCR) rcr_ff <= reg_wdata;
      if (transmit_clock_input_ff != transmit_clock_input) idle_ff <= 6'h00;
      else if (idle_ff != 6'h3F) idle_ff <= idle_ff + 6'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata_ff == 8'h00)
    else $error("read data not zero outside read answer");
  a_read_answer: assert property (reg_read && reg_addr == `TFRC_ADDR_TCR |=> reg_rdata_ff == tcr_ff)
    else $error("transmit control read back wrong");
  a_blue_line: assert property (tcr_ff[1] && $past(tcr_ff[1]) |->
    line_out_positive_ff && line_out_negative_ff)
    else $error("blue alarm not all ones on line");
  a_zbtsi_follow: assert property (rcr_ff[6] == $past(rcr_ff[6]) |->
    zbtsi_decode_en_ff == rcr_ff[6])
    else $error("interchange decode enable wrong");
  a_yellow_form: assert property (rcr_ff[2] == $past(rcr_ff[2]) |->
    rx_yellow_form_ff == rcr_ff[2])
    else $error("receive yellow form wrong");
  a_sync_input: assert property (rcr_ff[3] && $past(rcr_ff[3]) |-> !receive_sync_pin_oe_ff)
    else $error("sync pin driven in input mode");
  a_fallback_off: assert property ((!tcr_ff[7]) [*3] |-> !tx_clock_sel_ff)
    else $error("clock switched while fallback off");
  a_fallback_on: assert property (tcr_ff[7] && idle_ff > 6'd30 |=> tx_clock_sel_ff)
    else $error("no switch after line clock loss");
  a_buf_hold: assert property (out_valid_ff && !out_ready |=> out_valid_ff && $stable(out_byte_ff))
    else $error("buffer output dropped during stall");
  a_buf_push: assert property (rx_valid && rx_ready_ff |=> out_valid_ff)
    else $error("accepted word not offered");
endmodule // tfrc_ctrl_sva
bind tfrc_framer_ctrl tfrc_ctrl_sva u_tfrc_ctrl_sva (.*);

// ===== sim/tfrc_line_model.sv
// Line side model: transmit line clock with a stop control, recovered receive clock.
`timescale 1ns/10ps
module tfrc_line_model (
  input  wire logic clock,
  input  wire logic run,
  output logic      transmit_clock_input,
  output logic      recv_clock_input
);
  logic [1:0] div_ff;
  initial begin
    div_ff = 2'h0;
    transmit_clock_input = 1'b0;
    recv_clock_input = 1'b0;
  end
  always @(posedge clock) begin
    div_ff <= div_ff + 2'h1;
    recv_clock_input <= div_ff[1];
    if (run && div_ff[0]) transmit_clock_input <= !transmit_clock_input;
  end
endmodule // tfrc_line_model

// ===== sim/tb_top.sv
// Self-checking bench of the framer control block.
`timescale 1ns/10ps
`include "tfrc_regs.vh"
module tb_top;
  logic        clock, reset, reg_write, reg_read, run, out_ready, rx_valid, rx_code_sub;
  logic        transmit_clock_input, recv_clock_input, transmit_serial_input;
  logic        transmit_link_pin, tx_sig_bit, tx_esf_mode, receive_sync_pin_in;
  logic        rx_frame_start, rx_mf_start, rx_sig_frame, rx_fbit_err, rx_fs_err, rx_oos_mf;
  logic        rx_ready_ff, receive_sync_pin_out_ff, receive_sync_pin_oe_ff, out_valid_ff;
  logic        line_out_positive_ff, line_out_negative_ff, tx_clock_sel_ff;
  logic        zbtsi_decode_en_ff, rx_yellow_form_ff;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_ff, rx_byte, out_byte_ff;
  logic [15:0] pcv_count_ff, mos_count_ff;
  int          err_total, cmp_count;
  logic [7:0]  mw [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
  tfrc_framer_ctrl u_tfrc_framer_ctrl (.*);
  tfrc_line_model u_tfrc_line_model (.*);
  always #50 clock = ~clock;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata_ff, e);
  endtask
  task automatic xfer(input logic [7:0] b, input logic [7:0] e);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clock);
    rx_valid <= 1'b0;
    #1 chk(out_byte_ff, e);
  endtask
  task automatic ev(input logic [5:0] v, input logic [15:0] pe, input logic [15:0] me);
    @(posedge clock);
    {rx_fbit_err, rx_fs_err, rx_oos_mf, rx_frame_start, rx_mf_start, rx_sig_frame} <= v;
    @(posedge clock);
    {rx_fbit_err, rx_fs_err, rx_oos_mf, rx_frame_start, rx_mf_start, rx_sig_frame} <= 6'h00;
    repeat (3) @(posedge clock);
    #1 chk(pcv_count_ff, pe);
    chk(mos_count_ff, me);
  endtask
  task automatic print_verdict;
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_regs;
    rd(`TFRC_ADDR_TCR, 8'h00);
    rd(`TFRC_ADDR_RCR, 8'h00);
    wr(`TFRC_ADDR_TTR0, 8'h3C);
    rd(`TFRC_ADDR_TTR0, 8'h3C);
    wr(`TFRC_ADDR_RCR, 8'h52);
    rd(`TFRC_ADDR_RCR, 8'h52);
    rd(8'h00, 8'h00);
    wr(`TFRC_ADDR_RCR, 8'h00);
  endtask
  task automatic t_code;
    rx_code_sub <= 1'b1;
    xfer(8'h55, `TFRC_IDLE_CODE);
    wr(`TFRC_ADDR_RCR, 8'h80);
    for (int i = 0; i < 8; i++) xfer(8'h55, mw[i]);
    wr(`TFRC_ADDR_RCR, 8'h00);
    rx_code_sub <= 1'b0;
  endtask
  task automatic t_buffer;
    @(posedge clock);
    out_ready <= 1'b0;
    rx_valid <= 1'b1;
    rx_byte <= 8'h11;
    @(posedge clock);
    rx_byte <= 8'h22;
    @(posedge clock);
    rx_byte <= 8'h33;
    repeat (3) @(posedge clock);
    #1 chk(rx_ready_ff, 1'b0);
    chk(out_byte_ff, 8'h11);
    @(posedge clock);
    rx_valid <= 1'b0;
    out_ready <= 1'b1;
    @(posedge clock);
    #1 chk(out_byte_ff, 8'h22);
    @(posedge clock);
    #1 chk(out_valid_ff, 1'b0);
  endtask
  task automatic t_modes;
    transmit_serial_input <= 1'b1;
    transmit_link_pin <= 1'b1;
    wr(`TFRC_ADDR_TCR, 8'h02);
    repeat (3) @(posedge clock);
    #1 chk({line_out_positive_ff, line_out_negative_ff}, 2'h3);
    wr(`TFRC_ADDR_TCR, 8'h00);
    wr(`TFRC_ADDR_CCR, 8'h04);
    wr(`TFRC_ADDR_RCR, 8'h4C);
    repeat (3) @(posedge clock);
    #1 chk({zbtsi_decode_en_ff, rx_yellow_form_ff, receive_sync_pin_oe_ff}, 3'h6);
    wr(`TFRC_ADDR_RCR, 8'h00);
    repeat (3) @(posedge clock);
    #1 chk({zbtsi_decode_en_ff, rx_yellow_form_ff, receive_sync_pin_oe_ff}, 3'h1);
  endtask
  task automatic t_fallback;
    run <= 1'b0;
    repeat (40) @(posedge clock);
    #1 chk(tx_clock_sel_ff, 1'b0);
    wr(`TFRC_ADDR_TCR, 8'h80);
    repeat (5) @(posedge clock);
    #1 chk(tx_clock_sel_ff, 1'b1);
    rd(`TFRC_ADDR_STAT, 8'h02);
    run <= 1'b1;
    wr(`TFRC_ADDR_TCR, 8'h00);
  endtask
  task automatic t_counts;
    ev(6'h10, 16'h0000, 16'h0000);
    ev(6'h24, 16'h0001, 16'h0001);
    wr(`TFRC_ADDR_RCR, 8'h03);
    ev(6'h12, 16'h0002, 16'h0001);
    ev(6'h09, 16'h0002, 16'h0002);
    ev(6'h20, 16'h0003, 16'h0002);
  endtask
  task automatic t_sync;
    wr(`TFRC_ADDR_RCR, 8'h20);
    @(posedge clock);
    {rx_frame_start, rx_sig_frame} <= 2'h3;
    @(posedge clock);
    {rx_frame_start, rx_sig_frame} <= 2'h0;
    #1 chk(receive_sync_pin_out_ff, 1'b1);
    @(posedge clock);
    #1 chk(receive_sync_pin_out_ff, 1'b1);
    @(posedge clock);
    #1 chk(receive_sync_pin_out_ff, 1'b0);
    wr(`TFRC_ADDR_RCR, 8'h10);
    @(posedge clock);
    rx_mf_start <= 1'b1;
    @(posedge clock);
    rx_mf_start <= 1'b0;
    #1 chk(receive_sync_pin_out_ff, 1'b1);
    @(posedge clock);
    #1 chk(receive_sync_pin_out_ff, 1'b0);
  endtask
  initial begin
    {clock, reg_write, reg_read, rx_valid, rx_code_sub, transmit_serial_input} = 6'h00;
    {transmit_link_pin, tx_sig_bit, tx_esf_mode, receive_sync_pin_in} = 4'h0;
    {rx_fbit_err, rx_fs_err, rx_oos_mf, rx_frame_start, rx_mf_start, rx_sig_frame} = 6'h00;
    {reg_addr, reg_wdata, rx_byte} = 24'h000000;
    {reset, run, out_ready} = 3'h7;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_code();
    t_buffer();
    t_modes();
    t_fallback();
    t_counts();
    t_sync();
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    print_verdict();
  end
endmodule // tb_top
